// ===== design/gpdm_pkg.sv
// shared constants for the port data and pin mode block
`default_nettype none
package gpdm_pkg;
  // register byte addresses (data registers, then added mode/latch/bit-op/status)
  localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
  localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
  localparam logic [7:0] ADDR_PORT2_DATA = 8'ha0;
  localparam logic [7:0] ADDR_PORT3_DATA = 8'hb0;
  localparam logic [7:0] ADDR_MODE_HI_BASE = 8'hc0;
  localparam logic [7:0] ADDR_MODE_LO_BASE = 8'hd0;
  localparam logic [7:0] ADDR_LATCH_BASE = 8'he0;
  localparam logic [7:0] ADDR_BIT_OP = 8'hf0;
  localparam logic [7:0] ADDR_STATUS = 8'hf4;
  // reset values
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [31:0] MODE_HI_RESET = 32'hffff_ffff;
  localparam logic [31:0] MODE_LO_RESET = 32'h0000_0000;
  // pin mode encoding {mode_hi, mode_lo}
  localparam logic [1:0] MODE_QUASI = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
  localparam logic [1:0] MODE_INPUT = 2'h2;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;
  // system clock source select input
  localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;
  localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h1;
  localparam logic [1:0] CLK_SRC_CRYSTAL = 2'h2;
  // shared pin positions in the flat 32-pin vector
  localparam int PIN_CRYSTAL_IN = 8;
  localparam int PIN_CRYSTAL_OUT = 9;
  localparam int PIN_RESET = 10;
  // pins that never exist: port1 bits 7:3 and port2 bit 7
  localparam logic [31:0] PIN_ABSENT = 32'h0080_f800;
  // strong pull-up pulse after a 0 to 1 latch change, in cpu cycles
  localparam logic [1:0] STRONG_PULSE_CYCLES = 2'h2;
  // bit-op register fields
  localparam int BITOP_BIT_LSB = 0;
  localparam int BITOP_PORT_LSB = 3;
  localparam int BITOP_OP_LSB = 5;
  localparam int BITOP_VAL_POS = 7;
  localparam logic [1:0] BITOP_CLEAR = 2'h0;
  localparam logic [1:0] BITOP_SET = 2'h1;
  localparam logic [1:0] BITOP_COMPLEMENT = 2'h2;
  localparam logic [1:0] BITOP_MOVE = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpdm_pkg
`default_nettype wire

// ===== design/gpdm_top.sv
// four byte-wide gpio ports: latches, pin modes, pad enables and axi4-lite registers
//
// Register access over AXI4-Lite is this design's own decision.
`default_nettype none
module gpdm_top (
  input wire logic clk, // 200 mhz system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic reset_pin_disable, // config bit, 0 makes port1 bit2 a gpio input
  input wire logic [1:0] clk_source, // system clock source select
  input wire logic [31:0] pin_in, // pad input levels, port n in bits 8n+7:8n
  output logic [31:0] pull_down_en, // pad pull-down driver enable
  output logic [31:0] strong_pull_up_en, // pad strong pull-up enable
  output logic [31:0] weak_pull_up_en // pad weak pull-up enable
);

  // ==========================================================================
  // pin availability
  // ==========================================================================
  logic [31:0] latch_ff; // output latches, all ports
  logic [31:0] mode_hi_ff; // pin_mode_select_hi for all ports
  logic [31:0] mode_lo_ff; // pin_mode_select_lo for all ports
  logic [31:0] drive_ok; // pins whose latch and pad drivers are in use
  logic [31:0] read_ok; // pins whose level is visible on read
  logic [31:0] nxt_latch;

  // shared pins drop out of the gpio set depending on clock and reset straps
  always_comb begin
    drive_ok = ~gpdm_pkg::PIN_ABSENT;
    drive_ok[gpdm_pkg::PIN_RESET] = 1'b0;
    drive_ok[gpdm_pkg::PIN_CRYSTAL_OUT] = (clk_source != gpdm_pkg::CLK_SRC_CRYSTAL);
    drive_ok[gpdm_pkg::PIN_CRYSTAL_IN] = (clk_source == gpdm_pkg::CLK_SRC_INTERNAL);
    read_ok = drive_ok;
    // input-only gpio only when reset function disabled
    read_ok[gpdm_pkg::PIN_RESET] = ~reset_pin_disable;
  end

  // ==========================================================================
  // axi4-lite slave
  // ==========================================================================
  logic aw_take; // both write channels taken at this edge
  logic ar_take; // read address taken at this edge
  logic [1:0] port_sel_w; // port addressed by write
  logic [7:0] wbyte; // low data byte
  logic wr_hit; // write address decodes
  logic [31:0] rd_val; // read mux value
  logic rd_hit; // read address decodes

  assign aw_take = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign port_sel_w = s_axi_awaddr[3:2];
  assign wbyte = s_axi_wdata[7:0];

  // write handshake: ready for one cycle once both channels wait, response after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
    end
  end

  // write response held until accepted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gpdm_pkg::RESP_OKAY;
    end else if (aw_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? gpdm_pkg::RESP_OKAY : gpdm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // write decode: only the low byte lane carries register data
  always_comb begin
    wr_hit = 1'b1;
    case (s_axi_awaddr)
      gpdm_pkg::ADDR_PORT0_DATA, gpdm_pkg::ADDR_PORT1_DATA,
      gpdm_pkg::ADDR_PORT2_DATA, gpdm_pkg::ADDR_PORT3_DATA,
      gpdm_pkg::ADDR_BIT_OP: wr_hit = 1'b1;
      default: begin
        wr_hit = (s_axi_awaddr[7:4] == gpdm_pkg::ADDR_MODE_HI_BASE[7:4])
               | (s_axi_awaddr[7:4] == gpdm_pkg::ADDR_MODE_LO_BASE[7:4]);
        wr_hit = wr_hit & (s_axi_awaddr[1:0] == 2'h0);
      end
    endcase
  end

  // next latch value: byte loads and single-bit operations
  always_comb begin
    logic [4:0] idx;
    logic [1:0] op;
    logic [7:0] old_byte;
    logic [7:0] new_byte;
    idx = {s_axi_wdata[gpdm_pkg::BITOP_PORT_LSB +: 2], s_axi_wdata[gpdm_pkg::BITOP_BIT_LSB +: 3]};
    op = s_axi_wdata[gpdm_pkg::BITOP_OP_LSB +: 2];
    old_byte = latch_ff[{idx[4:3], 3'h0} +: 8];
    new_byte = old_byte;
    nxt_latch = latch_ff;
    if (aw_take && s_axi_wstrb[0]) begin
      if (s_axi_awaddr[7:4] >= gpdm_pkg::ADDR_PORT0_DATA[7:4]
          && s_axi_awaddr[7:4] <= gpdm_pkg::ADDR_PORT3_DATA[7:4]
          && s_axi_awaddr[3:0] == 4'h0) begin
        nxt_latch[{s_axi_awaddr[5:4], 3'h0} +: 8] = wbyte;
      end else if (s_axi_awaddr == gpdm_pkg::ADDR_BIT_OP) begin
        // whole latch byte read back, one bit changed
        case (op)
          gpdm_pkg::BITOP_CLEAR: new_byte[idx[2:0]] = 1'b0;
          gpdm_pkg::BITOP_SET: new_byte[idx[2:0]] = 1'b1;
          gpdm_pkg::BITOP_COMPLEMENT: new_byte[idx[2:0]] = ~old_byte[idx[2:0]];
          default: new_byte[idx[2:0]] = s_axi_wdata[gpdm_pkg::BITOP_VAL_POS];
        endcase
        nxt_latch[{idx[4:3], 3'h0} +: 8] = new_byte;
      end
    end
    nxt_latch = (nxt_latch & drive_ok) | (latch_ff & ~drive_ok);
  end

  // output latches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_ff <= {4{gpdm_pkg::DATA_RESET}};
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // mode registers, one word per port in each bank
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_hi_ff <= gpdm_pkg::MODE_HI_RESET;
      mode_lo_ff <= gpdm_pkg::MODE_LO_RESET;
    end else if (aw_take && s_axi_wstrb[0] && s_axi_awaddr[1:0] == 2'h0) begin
      if (s_axi_awaddr[7:4] == gpdm_pkg::ADDR_MODE_HI_BASE[7:4]) begin
        mode_hi_ff[{port_sel_w, 3'h0} +: 8] <= wbyte;
      end
      if (s_axi_awaddr[7:4] == gpdm_pkg::ADDR_MODE_LO_BASE[7:4]) begin
        mode_lo_ff[{port_sel_w, 3'h0} +: 8] <= wbyte;
      end
    end
  end

  // read mux: data registers give pins, latch registers give latches
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = (s_axi_araddr[1:0] == 2'h0);
    if (s_axi_araddr[7:4] >= gpdm_pkg::ADDR_PORT0_DATA[7:4]
        && s_axi_araddr[7:4] <= gpdm_pkg::ADDR_PORT3_DATA[7:4]
        && s_axi_araddr[3:0] == 4'h0) begin
      rd_val[7:0] = pin_in[{s_axi_araddr[5:4], 3'h0} +: 8]
                  & read_ok[{s_axi_araddr[5:4], 3'h0} +: 8];
    end else if (s_axi_araddr[7:4] == gpdm_pkg::ADDR_MODE_HI_BASE[7:4]) begin
      rd_val[7:0] = mode_hi_ff[{s_axi_araddr[3:2], 3'h0} +: 8];
    end else if (s_axi_araddr[7:4] == gpdm_pkg::ADDR_MODE_LO_BASE[7:4]) begin
      rd_val[7:0] = mode_lo_ff[{s_axi_araddr[3:2], 3'h0} +: 8];
    end else if (s_axi_araddr[7:4] == gpdm_pkg::ADDR_LATCH_BASE[7:4]) begin
      rd_val[7:0] = latch_ff[{s_axi_araddr[3:2], 3'h0} +: 8]
                  & drive_ok[{s_axi_araddr[3:2], 3'h0} +: 8];
    end else if (s_axi_araddr == gpdm_pkg::ADDR_STATUS) begin
      rd_val[2:0] = {clk_source, reset_pin_disable};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read channel: one request at a time, data held until accepted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= gpdm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? rd_val : 32'h0000_0000;
        s_axi_rresp <= rd_hit ? gpdm_pkg::RESP_OKAY : gpdm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // pad drivers, one slice per pin
  // ==========================================================================
  logic [31:0] latch_prev_ff; // latch one cycle ago, for rise detect

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_prev_ff <= {4{gpdm_pkg::DATA_RESET}};
    end else begin
      latch_prev_ff <= latch_ff;
    end
  end

  for (genvar i = 0; i < 32; i++) begin : g_pin
    logic [1:0] mode;
    logic [1:0] pulse_ff; // strong pull-up cycles left
    logic nxt_pd;
    logic nxt_strong;
    logic nxt_weak;

    // mode encoding, hi is upper bit
    assign mode = {mode_hi_ff[i], mode_lo_ff[i]};

    // two-cycle strong pull-up on 0 to 1 in quasi mode
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pulse_ff <= 2'h0;
      end else if (mode == gpdm_pkg::MODE_QUASI && latch_ff[i] && !latch_prev_ff[i]) begin
        pulse_ff <= gpdm_pkg::STRONG_PULSE_CYCLES - 2'h1;
      end else if (pulse_ff != 2'h0) begin
        pulse_ff <= pulse_ff - 2'h1;
      end
    end

    // enables from mode and latch; the rise term covers the rise cycle itself, pulse_ff the cycle after
    always_comb begin
      nxt_pd = 1'b0;
      nxt_strong = 1'b0;
      nxt_weak = 1'b0;
      case (mode)
        gpdm_pkg::MODE_QUASI: begin
          nxt_pd = ~latch_ff[i];
          nxt_strong = (latch_ff[i] & ~latch_prev_ff[i]) | (pulse_ff != 2'h0);
          nxt_weak = latch_ff[i];
        end
        gpdm_pkg::MODE_PUSH_PULL: begin
          nxt_pd = ~latch_ff[i];
          nxt_strong = latch_ff[i];
        end
        gpdm_pkg::MODE_OPEN_DRAIN: nxt_pd = ~latch_ff[i];
        default: nxt_pd = 1'b0;
      endcase
      if (!drive_ok[i]) begin
        nxt_pd = 1'b0;
        nxt_strong = 1'b0;
        nxt_weak = 1'b0;
      end
      if (i == gpdm_pkg::PIN_RESET) begin
        // pull-up from mode low bit 2, forced on as reset pin
        nxt_weak = reset_pin_disable | mode_lo_ff[i];
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pull_down_en[i] <= 1'b0;
        strong_pull_up_en[i] <= 1'b0;
        weak_pull_up_en[i] <= 1'b0;
      end else begin
        pull_down_en[i] <= nxt_pd;
        strong_pull_up_en[i] <= nxt_strong;
        weak_pull_up_en[i] <= nxt_weak;
      end
    end
  end

endmodule : gpdm_top
`default_nettype wire

// ===== test/gpdm_assertions.sv
// concurrent checks on the gpio port block ports
`default_nettype none
module gpdm_checker (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic reset_pin_disable, // shared reset pin config
  input wire logic [31:0] pull_down_en, // pad pull-down
  input wire logic [31:0] strong_pull_up_en, // pad strong pull-up
  input wire logic [31:0] weak_pull_up_en // pad weak pull-up
);
  // =====
  // bus handshakes, one clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_wans; s_axi_awready && s_axi_wready |=> s_axi_bvalid; endproperty
  a_wans: assert property (p_wans) else $error("write answer late");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  // =====
  // pads: a pin is never pulled both ways, absent pins never drive
  property p_nofight; (pull_down_en & (strong_pull_up_en | weak_pull_up_en)) == 32'h0; endproperty
  a_nofight: assert property (p_nofight) else $error("pull-down and pull-up together");
  property p_absent; ((pull_down_en | strong_pull_up_en | weak_pull_up_en) & gpdm_pkg::PIN_ABSENT) == 32'h0; endproperty
  a_absent: assert property (p_absent) else $error("absent pin driven");
  // the release edge itself still sees the pads in reset, so it starts no attempt
  property p_rstpin; !rst && reset_pin_disable |=> weak_pull_up_en[10] && !pull_down_en[10]
    && !strong_pull_up_en[10]; endproperty
  a_rstpin: assert property (p_rstpin) else $error("reset pin pad wrong");
  property p_relq; $fell(rst) |-> (pull_down_en | strong_pull_up_en) == 32'h0; endproperty
  a_relq: assert property (p_relq) else $error("pads driven after reset");
endmodule : gpdm_checker
bind gpdm_top gpdm_checker i_gpdm_checker (.clk, .rst, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .reset_pin_disable, .pull_down_en, .strong_pull_up_en,
  .weak_pull_up_en);
`default_nettype wire

// ===== test/gpdm_pads_model.sv
// board circuitry hanging on the port pins
`default_nettype none
module gpdm_pads_model (
  input wire logic [31:0] pull_down_en, // pad pull-down
  input wire logic [31:0] strong_pull_up_en, // pad strong pull-up
  input wire logic [31:0] weak_pull_up_en, // pad weak pull-up
  input wire logic [31:0] ext_level, // resistor level on released pins
  output logic [31:0] pin_in // level seen at the pads
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin follows its driver; a released one falls to its resistor, never a stale value
  assign pin_in = ~pull_down_en & (strong_pull_up_en | weak_pull_up_en | ext_level);
endmodule : gpdm_pads_model
`default_nettype wire

// ===== test/gpdm_top_bench.sv
// self-checking bench for the gpio port block
`default_nettype none
module gpdm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [1:0] r;} gpdm_row_t;
  // =====
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, reset_pin_disable = 1'b0;
  logic [1:0] clk_source = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, pin_in, pull_down_en, strong_pull_up_en, weak_pull_up_en;
  logic [31:0] ext_level = 32'h5abcff96;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int pulse_len = 0;
  int base = 0;
  bit late_rdy = 1'b0; // raise bready/rready only after the answer is seen
  // reads, then latch and bit-op traffic on port 0 and port 1
  gpdm_row_t rows [22] = '{'{1'b0, 8'he0, 8'hff, 2'h0}, '{1'b0, 8'he8, 8'h7f, 2'h0},
    '{1'b0, 8'he4, 8'h03, 2'h0}, '{1'b0, 8'hc0, 8'hff, 2'h0}, '{1'b0, 8'hd0, 8'h00, 2'h0},
    '{1'b0, 8'h80, 8'h96, 2'h0}, '{1'b0, 8'h90, 8'h07, 2'h0}, '{1'b0, 8'ha0, 8'h3c, 2'h0},
    '{1'b0, 8'hb0, 8'h5a, 2'h0}, '{1'b0, 8'hf4, 8'h00, 2'h0}, '{1'b0, 8'h44, 8'h00, 2'h2},
    '{1'b1, 8'h81, 8'h00, 2'h2}, '{1'b1, 8'h80, 8'h00, 2'h0}, '{1'b0, 8'he0, 8'h00, 2'h0},
    '{1'b0, 8'h80, 8'h96, 2'h0}, '{1'b1, 8'hf0, 8'h26, 2'h0}, '{1'b1, 8'hf0, 8'h40, 2'h0},
    '{1'b1, 8'hf0, 8'h06, 2'h0}, '{1'b1, 8'hf0, 8'he3, 2'h0}, '{1'b0, 8'he0, 8'h09, 2'h0},
    '{1'b1, 8'h90, 8'h00, 2'h0}, '{1'b0, 8'he4, 8'h00, 2'h0}};
  gpdm_top i_gpdm_top (.*);
  gpdm_pads_model i_gpdm_pads_model (.pull_down_en, .strong_pull_up_en, .weak_pull_up_en,
    .ext_level, .pin_in);
  // =====
  // clock, hang guard and strong pull-up length on pin 0
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (strong_pull_up_en[0] === 1'b1) pulse_len <= pulse_len + 1;
    if (cycles == 4000) begin
      fail_count = fail_count + 1;
      finish_test();
    end
  end
  // =====
  // checking and bus tasks; each request waits for its own ready
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !late_rdy;
    // each channel is released at the edge that takes it, not before
    while (aw_left || w_left) begin
      @(posedge clk);
      if (aw_left && s_axi_awready === 1'b1) begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1) begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
      if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1) s_axi_bready <= 1'b1;
    end while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !late_rdy;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // data is taken only at the edge where rvalid and rready are both high
    do begin
      @(posedge clk);
      if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1) s_axi_rready <= 1'b1;
    end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h000000, e}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : bus_rd
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // =====
  // main sequence: table first, then pad modes, shared pins and a second reset
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        bus_wr(rows[i].a, rows[i].d, rows[i].r);
      end else begin
        bus_rd(rows[i].a, rows[i].d, rows[i].r);
      end
    end
    // pins 0..3 of port 0: quasi, push-pull, input-only, open-drain
    bus_wr(8'hc0, 8'h0c, 2'h0);
    bus_wr(8'hd0, 8'h0a, 2'h0);
    bus_wr(8'h80, 8'h00, 2'h0);
    repeat (2) @(posedge clk);
    chk("pull_down", 32'hfb, pull_down_en & 32'hff);
    chk("input_pu", 32'h0, (strong_pull_up_en | weak_pull_up_en) & 32'h0c);
    bus_rd(8'h80, 8'h04, 2'h0);
    base = pulse_len;
    bus_wr(8'h80, 8'hff, 2'h0);
    repeat (4) @(posedge clk);
    chk("pulse", 32'd2, 32'(pulse_len - base));
    chk("strong", 32'h2, strong_pull_up_en & 32'hf);
    chk("od_off", 32'h0, (pull_down_en | strong_pull_up_en | weak_pull_up_en) & 32'hc);
    bus_rd(8'h80, 8'hf7, 2'h0);
    // crystal pins ignore writes and read zero
    // late ready here keeps answers waiting, so the hold checks get exercised
    clk_source <= gpdm_pkg::CLK_SRC_CRYSTAL;
    late_rdy = 1'b1;
    bus_wr(8'h90, 8'hff, 2'h0);
    bus_rd(8'h90, 8'h04, 2'h0);
    bus_rd(8'hf4, 8'h04, 2'h0);
    late_rdy = 1'b0;
    clk_source <= gpdm_pkg::CLK_SRC_EXTERNAL;
    bus_rd(8'he4, 8'h00, 2'h0);
    bus_rd(8'h90, 8'h06, 2'h0);
    bus_wr(8'hd4, 8'h04, 2'h0);
    @(posedge clk);
    chk("rst_pin_pu", 32'h1, {31'h0, weak_pull_up_en[10]});
    reset_pin_disable <= 1'b1;
    bus_rd(8'h90, 8'h02, 2'h0);
    // reset in mid-run brings latches and modes back
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus_rd(8'he0, 8'hff, 2'h0);
    // a write with the low byte lane off must leave the latch alone
    s_axi_wstrb <= 4'he;
    bus_wr(8'h80, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hf;
    bus_rd(8'he0, 8'hff, 2'h0);
    bus_rd(8'hd4, 8'h00, 2'h0);
    finish_test();
  end
endmodule : gpdm_top_bench
`default_nettype wire
